/* File: core/power_calc_engine.sv */
/*
 Measurement sequencer and arithmetic core of a current and power monitor.
 Runs shunt and bus conversions, averages them, derives current and power.
 Assumes a register port from a serial slave on i_core_clk and raw converter
 words from the analog side, which are asynchronous and held stable while
 a conversion ends.
*/
`timescale 1ns/1ps
`default_nettype none
module power_calc_engine #(
   parameter int CYCLES_PER_US = meas_pkg::CLOCK_MHZ
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Register port
   input wire logic [2:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   // Converter words
   input wire logic [15:0] i_shunt_adc,
   input wire logic [15:0] i_bus_sense_input,
   // Status
   output logic o_busy,
   output logic o_set_done
);
   function automatic logic signed [39:0] tz_shift(input logic signed [39:0] v,
                                                   input logic [3:0] sh);
      logic signed [39:0] r;
      r = (v < 0) ? -((-v) >>> sh) : (v >>> sh);
      return r;
   endfunction

   logic [11:0] cfg_q;
   logic [15:0] cal_q;
   logic [15:0] shunt_q, bus_q, cur_q, pwr_q;
   logic signed [39:0] acc_sh_q, acc_bus_q, acc_cur_q, acc_pwr_q;
   logic [10:0] smp_cnt_q;
   logic signed [15:0] last_cur_q;
   logic trig_q;
   logic [15:0] sh_s1_q, sh_s2_q, bus_s1_q, bus_s2_q;
   meas_pkg::seq_state_e state_q, state_d;

   wire wr_cfg = i_reg_wr && (i_reg_addr == meas_pkg::REG_CONFIG);
   wire wr_cal = i_reg_wr && (i_reg_addr == meas_pkg::REG_CALIB);
   wire [2:0] mode = cfg_q[meas_pkg::CFG_MODE_LSB +: 3];
   wire do_sh = mode[meas_pkg::MODE_SHUNT_BIT];
   wire do_bus = mode[meas_pkg::MODE_BUS_BIT];
   wire cont = mode[meas_pkg::MODE_CONT_BIT];
   wire cal_loaded = (cal_q != 16'h0);
   wire [3:0] avg_sh = meas_pkg::avg_shift(cfg_q[meas_pkg::CFG_AVG_LSB +: 3]);
   wire [10:0] avg_last = 11'((32'h1 << avg_sh) - 32'h1);
   wire [31:0] sh_cycles = 32'(meas_pkg::conv_us(cfg_q[meas_pkg::CFG_SHCT_LSB +: 3])
                               * CYCLES_PER_US);
   wire [31:0] bus_cycles = 32'(meas_pkg::conv_us(cfg_q[meas_pkg::CFG_BUSCT_LSB +: 3])
                                * CYCLES_PER_US);

   wire timer_done;
   wire sh_done = (state_q == meas_pkg::ST_SHUNT) && timer_done;
   wire bus_done = (state_q == meas_pkg::ST_BUS) && timer_done;
   wire smp_end = (sh_done && !do_bus) || bus_done;
   wire set_end = smp_end && (smp_cnt_q == avg_last);
   wire idle_go = (state_q == meas_pkg::ST_IDLE) && (do_sh || do_bus) && (cont || trig_q);
   wire restart = !wr_cfg && (idle_go || (smp_end && (!set_end || cont)));
   wire enter_sh = restart && do_sh;
   wire enter_bus = (restart && !do_sh) || (!wr_cfg && sh_done && do_bus);

   // Per-sample derived values from the raw measurements
   wire signed [15:0] sh_raw = $signed(sh_s2_q);
   wire [15:0] bus_raw = {1'b0, bus_s2_q[14:0]};
   wire signed [39:0] cur_prod = 40'(sh_raw * $signed({1'b0, cal_q}));
   wire signed [15:0] smp_cur = cal_loaded ?
      16'(tz_shift(cur_prod, meas_pkg::CURRENT_SHIFT)) : 16'sh0;
   wire [15:0] cur_mag = last_cur_q[15] ? 16'(-last_cur_q) : 16'(last_cur_q);
   wire [31:0] pwr_prod = 32'(cur_mag * bus_raw);
   // Unsigned quotient truncates toward zero; the fixed divisor gives the 25x step
   wire [15:0] smp_pwr = cal_loaded ?
      16'(pwr_prod / meas_pkg::POWER_DIVISOR) : 16'h0;

   // Running sums including this cycle's sample
   wire signed [39:0] sh_sum = acc_sh_q + (sh_done ? 40'(sh_raw) : 40'sh0);
   wire signed [39:0] cur_sum = acc_cur_q + (sh_done ? 40'(smp_cur) : 40'sh0);
   wire signed [39:0] bus_sum = acc_bus_q + (bus_done ? 40'($signed({1'b0, bus_raw}))
                                                        : 40'sh0);
   wire signed [39:0] pwr_sum = acc_pwr_q + (bus_done ? 40'($signed({1'b0, smp_pwr}))
                                                        : 40'sh0);

   logic [15:0] rdata;
   always_comb begin
      unique case (i_reg_addr)
         meas_pkg::REG_CONFIG: rdata = {meas_pkg::CFG_FIXED_TOP, cfg_q};
         meas_pkg::REG_SHUNT: rdata = shunt_q;
         meas_pkg::REG_BUS: rdata = bus_q;
         meas_pkg::REG_POWER: rdata = pwr_q;
         meas_pkg::REG_CURRENT: rdata = cur_q;
         meas_pkg::REG_CALIB: rdata = cal_q;
         default: rdata = 16'h0;
      endcase
   end

   always_comb begin
      state_d = state_q;
      if (wr_cfg) begin
         state_d = meas_pkg::ST_IDLE;
      end else if (enter_sh) begin
         state_d = meas_pkg::ST_SHUNT;
      end else if (enter_bus) begin
         state_d = meas_pkg::ST_BUS;
      end else if (smp_end) begin
         state_d = meas_pkg::ST_IDLE;
      end
   end

   conv_timer u_timer (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_start(enter_sh || enter_bus),
      .i_cycles(enter_sh ? sh_cycles : bus_cycles),
      .i_abort(wr_cfg),
      .o_done(timer_done)
   );

   // Converter words are asynchronous: two flops before use
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sh_s1_q <= 16'h0;
         sh_s2_q <= 16'h0;
         bus_s1_q <= 16'h0;
         bus_s2_q <= 16'h0;
      end else begin
         sh_s1_q <= i_shunt_adc;
         sh_s2_q <= sh_s1_q;
         bus_s1_q <= i_bus_sense_input;
         bus_s2_q <= bus_s1_q;
      end
   end

   // Configuration, calibration and sequencer state
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_q <= meas_pkg::CFG_RESET;
         cal_q <= 16'h0;
         trig_q <= 1'b0;
         state_q <= meas_pkg::ST_IDLE;
         o_reg_rdata <= 16'h0;
         o_busy <= 1'b0;
      end else begin
         o_reg_rdata <= rdata;
         state_q <= state_d;
         o_busy <= (state_d != meas_pkg::ST_IDLE);
         if (wr_cfg) begin
            cfg_q <= i_reg_wdata[11:0];
         end
         if (wr_cal) begin
            cal_q <= i_reg_wdata;
         end
         // A configuration write with the continuous bit clear re-arms a single-shot run
         trig_q <= wr_cfg ? !i_reg_wdata[meas_pkg::CFG_MODE_LSB + meas_pkg::MODE_CONT_BIT]
                          : (trig_q && !idle_go);
      end
   end

   // Accumulation and averaged result registers
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         acc_sh_q <= 40'sh0;
         acc_bus_q <= 40'sh0;
         acc_cur_q <= 40'sh0;
         acc_pwr_q <= 40'sh0;
         smp_cnt_q <= 11'h0;
         last_cur_q <= 16'sh0;
         shunt_q <= 16'h0;
         bus_q <= 16'h0;
         cur_q <= 16'h0;
         pwr_q <= 16'h0;
         o_set_done <= 1'b0;
      end else begin
         o_set_done <= set_end && !wr_cfg;
         if (sh_done) begin
            last_cur_q <= smp_cur;
         end
         if (wr_cfg || set_end) begin
            acc_sh_q <= 40'sh0;
            acc_bus_q <= 40'sh0;
            acc_cur_q <= 40'sh0;
            acc_pwr_q <= 40'sh0;
            smp_cnt_q <= 11'h0;
         end else begin
            acc_sh_q <= sh_sum;
            acc_bus_q <= bus_sum;
            acc_cur_q <= cur_sum;
            acc_pwr_q <= pwr_sum;
            smp_cnt_q <= smp_end ? smp_cnt_q + 11'h1 : smp_cnt_q;
         end
         if (set_end && !wr_cfg && do_sh) begin
            shunt_q <= 16'(tz_shift(sh_sum, avg_sh));
            cur_q <= cal_loaded ? 16'(tz_shift(cur_sum, avg_sh)) : 16'h0;
         end
         if (set_end && !wr_cfg && do_bus) begin
            bus_q <= {1'b0, 15'(tz_shift(bus_sum, avg_sh))};
            pwr_q <= cal_loaded ? 16'(tz_shift(pwr_sum, avg_sh)) : 16'h0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: pkg/meas_pkg.sv */
/*
 Constants shared by the measurement engine: register indices, configuration
 field layout, reset values, conversion-time and averaging tables, scaling.
 Assumes a 16-bit register word and a 125 MHz core clock.
*/
`default_nettype none
package meas_pkg;
   // Register indices on the register port
   localparam logic [2:0] REG_CONFIG = 3'h0;
   localparam logic [2:0] REG_SHUNT = 3'h1;
   localparam logic [2:0] REG_BUS = 3'h2;
   localparam logic [2:0] REG_POWER = 3'h3;
   localparam logic [2:0] REG_CURRENT = 3'h4;
   localparam logic [2:0] REG_CALIB = 3'h5;

   // Configuration word: [15:12] fixed, [11:9] averaging, [8:6] bus time,
   // [5:3] shunt time, [2:0] mode
   localparam logic [3:0] CFG_FIXED_TOP = 4'h4;
   localparam logic [11:0] CFG_RESET = 12'h127;
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_SHCT_LSB = 3;
   localparam int CFG_BUSCT_LSB = 6;
   localparam int CFG_AVG_LSB = 9;
   localparam int MODE_SHUNT_BIT = 0;
   localparam int MODE_BUS_BIT = 1;
   localparam int MODE_CONT_BIT = 2;

   // Arithmetic scaling
   localparam logic [3:0] CURRENT_SHIFT = 4'hb;
   localparam logic [31:0] POWER_DIVISOR = 32'h0000_4e20;
   localparam int CLOCK_MHZ = 125;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHUNT = 3'b010,
      ST_BUS = 3'b100
   } seq_state_e;

   // Conversion duration in microseconds for each 3-bit setting
   function automatic logic [31:0] conv_us(input logic [2:0] sel);
      logic [31:0] us;
      us = 32'h0;
      unique case (sel)
         3'h0: us = 32'h0000_008c;
         3'h1: us = 32'h0000_00cc;
         3'h2: us = 32'h0000_014c;
         3'h3: us = 32'h0000_024c;
         3'h4: us = 32'h0000_044c;
         3'h5: us = 32'h0000_0844;
         3'h6: us = 32'h0000_103c;
         3'h7: us = 32'h0000_2034;
      endcase
      return us;
   endfunction

   // Averaging count is a power of two: return its log2
   function automatic logic [3:0] avg_shift(input logic [2:0] sel);
      logic [3:0] s;
      s = 4'h0;
      unique case (sel)
         3'h0: s = 4'h0;
         3'h1: s = 4'h2;
         3'h2: s = 4'h4;
         3'h3: s = 4'h6;
         3'h4: s = 4'h7;
         3'h5: s = 4'h8;
         3'h6: s = 4'h9;
         3'h7: s = 4'ha;
      endcase
      return s;
   endfunction
endpackage
`default_nettype wire

/* File: core/conv_timer.sv */
/*
 One-shot conversion timer: counts a loaded number of core clocks and
 pulses done at the end. Assumes start is a one-cycle pulse on i_core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_timer (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Control
   input wire logic i_start,
   input wire logic [31:0] i_cycles,
   input wire logic i_abort,
   // Status
   output logic o_done
);
   logic [31:0] cnt_q;
   logic run_q;
   logic last;

   assign last = run_q && (cnt_q <= 32'h1);

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= 32'h0;
         run_q <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= last && !i_abort && !i_start;
         if (i_abort) begin
            run_q <= 1'b0;
         end else if (i_start) begin
            cnt_q <= i_cycles;
            run_q <= 1'b1;
         end else if (last) begin
            run_q <= 1'b0;
         end else if (run_q) begin
            cnt_q <= cnt_q - 32'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: bench/power_calc_engine_checker.sv */
/*
 Port assertions and covers for the measurement engine.
 Bound to every power_calc_engine; sees only its register and status ports.
*/
`timescale 1ns/1ps
`default_nettype none
module power_calc_engine_checker (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Register port
   input wire logic [2:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   // Status
   input wire logic o_busy,
   input wire logic o_set_done
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   wire logic cfg_wr = i_reg_wr && i_reg_addr == 3'h0;

   done_pulse_a: assert property (o_set_done |=> !o_set_done)
      else $error("set done held longer than one cycle");
   pdown_idle_a: assert property (cfg_wr && i_reg_wdata[1:0] == 2'h0 |-> ##2 !o_busy)
      else $error("busy after power-down write");
   mode_start_a: assert property (cfg_wr && i_reg_wdata[1:0] != 2'h0 |-> ##2 o_busy)
      else $error("no conversion after active mode write");
   cfg_fixed_a: assert property (i_reg_addr == 3'h0 |=> o_reg_rdata[15:12] == 4'h4)
      else $error("config top bits wrong");
   cfg_store_a: assert property (cfg_wr ##1 (i_reg_addr == 3'h0 && !i_reg_wr)
      |=> o_reg_rdata[11:0] == $past(i_reg_wdata[11:0], 2))
      else $error("config fields not stored");
   bus_msb_a: assert property (i_reg_addr == 3'h2 |=> !o_reg_rdata[15])
      else $error("bus result top bit set");
   unmapped_zero_a: assert property (i_reg_addr > 3'h5 |=> o_reg_rdata == 16'h0)
      else $error("unmapped read not zero");
   conv_min_a: assert property ($rose(o_busy) |-> (!o_set_done) [*8])
      else $error("result set too soon after start");

   cover property (o_set_done);
   cover property (cfg_wr && i_reg_wdata[2:0] == 3'h3);
   cover property (i_reg_addr == 3'h4 ##1 o_reg_rdata != 16'h0);
endmodule
bind power_calc_engine power_calc_engine_checker checker_inst (
   .i_core_clk(i_core_clk),
   .i_nrst(i_nrst),
   .i_reg_addr(i_reg_addr),
   .i_reg_wr(i_reg_wr),
   .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata),
   .o_busy(o_busy),
   .o_set_done(o_set_done)
);
`default_nettype wire

/* File: bench/host_model.sv */
/*
 Host model on the engine's register port, with the calibration arithmetic.
 Drives from i_core_clk rising edges; the bench calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock
   input wire logic i_core_clk,
   // Register port
   output logic [2:0] o_reg_addr,
   output logic o_reg_wr,
   output logic [15:0] o_reg_wdata,
   input wire logic [15:0] i_reg_rdata
);
   initial begin
      o_reg_addr = 3'h0;
      o_reg_wr = 1'b0;
      o_reg_wdata = 16'h0;
   end
   // Step below 1 mA is raised to 1 mA, trading resolution for easy conversion
   function automatic logic [15:0] cal_word(input real max_amp, input real r_shunt);
      real lsb;
      lsb = max_amp / 32768.0;
      lsb = (lsb <= 0.001) ? 0.001 : lsb;
      return 16'($rtoi(0.00512 / (lsb * r_shunt) + 0.5));
   endfunction
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      o_reg_addr <= a;
      o_reg_wr <= 1'b1;
      o_reg_wdata <= d;
      @(posedge i_core_clk);
      o_reg_wr <= 1'b0;
      o_reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge i_core_clk);
      o_reg_addr <= a;
      @(posedge i_core_clk);
      #1 d = i_reg_rdata;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
/*
 Self-checking bench for the measurement engine.
 Engine runs with one clock per microsecond so conversions stay short.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [2:0] reg_addr;
   logic reg_wr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [15:0] shunt_adc = 16'h1f40;
   logic [15:0] bus_adc = 16'h2570;
   logic busy;
   logic set_done;
   logic [15:0] rv;
   int fail_count = 0;
   int compares = 0;
   int n;
   int exp_cyc;
   int t_us [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
   int avg_n [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
   logic [15:0] cfgs [3] = '{16'h4207, 16'h40f7, 16'h403f};

   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end

   power_calc_engine #(.CYCLES_PER_US(1)) power_calc_engine_inst (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_reg_addr(reg_addr),
      .i_reg_wr(reg_wr),
      .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata),
      .i_shunt_adc(shunt_adc),
      .i_bus_sense_input(bus_adc),
      .o_busy(busy),
      .o_set_done(set_done)
   );
   host_model host_model_inst (
      .i_core_clk(i_core_clk),
      .o_reg_addr(reg_addr),
      .o_reg_wr(reg_wr),
      .o_reg_wdata(reg_wdata),
      .i_reg_rdata(reg_rdata)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Mismatches %0d of %0d compares", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Cycles up to the next result set; a set that never comes ends the run
   task automatic wait_set(output int cyc);
      cyc = 0;
      do begin
         @(posedge i_core_clk);
         #1 cyc++;
         if (cyc > 20000) begin
            fail_count++;
            end_of_test();
         end
      end while (set_done !== 1'b1);
   endtask
   task automatic one_set(input logic [15:0] sh, bus, cur, pwr);
      host_model_inst.wr(3'h0, 16'h4003);
      wait_set(n);
      host_model_inst.rd(3'h1, rv);
      check(rv, sh);
      host_model_inst.rd(3'h2, rv);
      check(rv, bus);
      host_model_inst.rd(3'h4, rv);
      check(rv, cur);
      host_model_inst.rd(3'h3, rv);
      check(rv, pwr);
   endtask

   initial begin
      repeat (3) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      host_model_inst.rd(3'h0, rv);
      check(rv, 16'h4127);
      host_model_inst.wr(3'h4, 16'hffff);
      host_model_inst.rd(3'h4, rv);
      check(rv, 16'h0000);
      host_model_inst.rd(3'h7, rv);
      check(rv, 16'h0000);
      one_set(16'h1f40, 16'h2570, 16'h0000, 16'h0000);
      host_model_inst.wr(3'h5, host_model_inst.cal_word(15.0, 0.002));
      host_model_inst.rd(3'h5, rv);
      check(rv, 16'h0a00);
      one_set(16'h1f40, 16'h2570, 16'h2710, 16'h12b8);
      @(posedge i_core_clk);
      shunt_adc <= 16'hf82f;
      bus_adc <= 16'hffff;
      one_set(16'hf82f, 16'h7fff, 16'hf63b, 16'h1001);
      // Continuous: spacing of sets against (shunt + bus) times averages
      foreach (cfgs[i]) begin
         host_model_inst.wr(3'h0, cfgs[i]);
         wait_set(n);
         wait_set(n);
         exp_cyc = avg_n[cfgs[i][11:9]] * (t_us[cfgs[i][5:3]] + t_us[cfgs[i][8:6]]);
         check({15'h0, n >= exp_cyc && n <= exp_cyc + 4 * avg_n[cfgs[i][11:9]]}, 16'h1);
      end
      host_model_inst.rd(3'h4, rv);
      check(rv, 16'hf63b);
      // Single-channel runs must leave the other channel's results alone
      @(posedge i_core_clk);
      shunt_adc <= 16'h1f40;
      bus_adc <= 16'h2570;
      host_model_inst.wr(3'h0, 16'h4001);
      wait_set(n);
      host_model_inst.rd(3'h2, rv);
      check(rv, 16'h7fff);
      host_model_inst.rd(3'h4, rv);
      check(rv, 16'h2710);
      host_model_inst.rd(3'h3, rv);
      check(rv, 16'h1001);
      // Shunt input moved so a stray shunt conversion would show up
      @(posedge i_core_clk);
      shunt_adc <= 16'h0000;
      host_model_inst.wr(3'h0, 16'h4002);
      wait_set(n);
      host_model_inst.rd(3'h1, rv);
      check(rv, 16'h1f40);
      host_model_inst.rd(3'h2, rv);
      check(rv, 16'h2570);
      host_model_inst.rd(3'h3, rv);
      check(rv, 16'h12b8);
      host_model_inst.wr(3'h0, 16'h4000);
      repeat (4) @(posedge i_core_clk);
      #1 check({15'h0, busy}, 16'h0000);
      end_of_test();
   end
endmodule
`default_nettype wire
